/* hdl/hsbc_map.svh */
// Offsets, bit positions, reset values and timing counts of the bus connect control
`ifndef HSBC_MAP_SVH
`define HSBC_MAP_SVH

`define HSBC_CLK_NS 50
`define HSBC_T_IDLE_NS 95000
`define HSBC_T_STOP_NS 1200
`define HSBC_IDLE_CYC ((`HSBC_T_IDLE_NS + `HSBC_CLK_NS - 1) / `HSBC_CLK_NS)
`define HSBC_STOP_CYC ((`HSBC_T_STOP_NS + `HSBC_CLK_NS - 1) / `HSBC_CLK_NS)
`define HSBC_SYNC_LAT 3

`define HSBC_ADR_STATUS 8'h00
`define HSBC_ADR_IDLE 8'h04

`define HSBC_ST_STATE_LSB 0
`define HSBC_ST_READY 3
`define HSBC_ST_LOCKOUT 4
`define HSBC_ST_SHUTDOWN 5
`define HSBC_ST_PRECHARGE 6
`define HSBC_ST_LINES_LSB 8
`define HSBC_ST_BOOST_LSB 12

`define HSBC_PIN_BP_CLK 0
`define HSBC_PIN_BP_DAT 1
`define HSBC_PIN_CARD_CLK 2
`define HSBC_PIN_CARD_DAT 3
`define HSBC_PIN_ENABLE 4
`define HSBC_PIN_SUPPLY 5

`endif

/* hdl/hsbc_pkg.sv */
// Types shared by the bus connect control
package hsbc_pkg;

  // Bit 0 backplane clock, 1 backplane data, 2 card clock, 3 card data
  typedef struct packed {
    logic card_data_line;
    logic card_clock_line;
    logic backplane_data_line;
    logic backplane_clock_line;
  } hsbc_lines_t;

  typedef enum logic [2:0] {
    HSBC_LOCKOUT = 3'b000,
    HSBC_SHUTDOWN = 3'b001,
    HSBC_WAIT_BUS = 3'b010,
    HSBC_WAIT_CARD = 3'b011,
    HSBC_QUALIFY = 3'b100,
    HSBC_CONNECTED = 3'b101
  } hsbc_state_t;

  typedef enum logic [1:0] {
    HSBC_OWN_NONE = 2'b00,
    HSBC_OWN_BP = 2'b01,
    HSBC_OWN_CARD = 2'b10,
    HSBC_OWN_SETTLE = 2'b11
  } hsbc_own_t;

endpackage : hsbc_pkg

/* hdl/hsbc_top.sv */
// Hot swap two-wire bus connect control with a classic Wishbone register slave
// Functional notes
// - Keep backplane and card lines isolated until qualified.
// - Ready low unless enabled and start-up done.
// - Enable low: isolate, no boost, precharge off.
// - Enable high again reruns the start-up qualification.
// - Supply low: lockout, all line activity ignored.
// - Precharge stays enabled during lockout.
// - After lockout watch backplane for stop or idle.
// - Then require both card lines high first.
// - Qualified: join lines and enable boost.
// - A low on either side pulls both low.
// - Joined line rises only when both released; here the owning side rises on release even if the other holds low.
// - Boost engages only on a rising edge.
// - Low during active boost may be lost.
// - Ready follows stop after about 1.2 us.
// - Enable low drops ready quickly.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "hsbc_map.svh"

module hsbc_top
  import hsbc_pkg::*;
#(
  parameter int IDLE_W = 16,
  parameter int BOOST_CYC = 2,
  parameter int SETTLE_CYC = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic supply_ok_i,
  input wire hsbc_lines_t line_i,
  output logic [3:0] line_o,
  output logic [3:0] line_oe_n_o,
  output logic [3:0] boost_o,
  output logic ready_o,
  output logic precharge_o,
  output logic shutdown_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam int BW = $clog2(BOOST_CYC + 1);
  localparam int SW = $clog2(SETTLE_CYC + `HSBC_SYNC_LAT + 1);
  localparam int QW = $clog2(`HSBC_STOP_CYC + 1);

  // Pin synchronisers: three stages, a change counts once stages two and three agree
  logic [5:0] pins;
  logic [5:0] sync1_ff;
  logic [5:0] sync2_ff;
  logic [5:0] sync3_ff;
  logic [5:0] filt_ff;

  assign pins = {supply_ok_i, enable_i, line_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 6'h00;
      sync2_ff <= 6'h00;
      sync3_ff <= 6'h00;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < 6; gp++) begin : g_filt
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          filt_ff[gp] <= 1'b0;
        end else if (sync2_ff[gp] == sync3_ff[gp]) begin
          filt_ff[gp] <= sync3_ff[gp];
        end
      end
    end
  endgenerate

  logic supply_ok;
  logic enabled;
  logic bp_clk;
  logic bp_dat;
  logic card_high;
  assign supply_ok = filt_ff[`HSBC_PIN_SUPPLY];
  assign enabled = filt_ff[`HSBC_PIN_ENABLE];
  assign bp_clk = filt_ff[`HSBC_PIN_BP_CLK];
  assign bp_dat = filt_ff[`HSBC_PIN_BP_DAT];
  assign card_high = filt_ff[`HSBC_PIN_CARD_CLK] & filt_ff[`HSBC_PIN_CARD_DAT];

  // Backplane stop and idle detection
  logic prev_clk_ff;
  logic prev_dat_ff;
  logic stop_det;
  logic idle_det;
  logic [IDLE_W-1:0] idle_cyc_ff;
  logic [IDLE_W-1:0] idle_cnt_ff;

  assign stop_det = bp_dat & ~prev_dat_ff & bp_clk & prev_clk_ff;
  assign idle_det = (idle_cnt_ff >= idle_cyc_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_clk_ff <= 1'b0;
      prev_dat_ff <= 1'b0;
    end else begin
      prev_clk_ff <= bp_clk;
      prev_dat_ff <= bp_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      idle_cnt_ff <= '0;
    end else if (!(bp_clk & bp_dat)) begin
      idle_cnt_ff <= '0;
    end else if (!idle_det) begin
      idle_cnt_ff <= idle_cnt_ff + 1'b1;
    end
  end

  // Start-up sequencer
  hsbc_state_t state_ff;
  hsbc_state_t nxt_state;
  logic [QW-1:0] qual_cnt_ff;
  logic connected;
  assign connected = (state_ff == HSBC_CONNECTED);

  always_comb begin
    nxt_state = state_ff;
    if (!supply_ok) begin
      nxt_state = HSBC_LOCKOUT;
    end else if (!enabled) begin
      nxt_state = HSBC_SHUTDOWN;
    end else begin
      case (state_ff)
        HSBC_LOCKOUT: nxt_state = HSBC_WAIT_BUS;
        HSBC_SHUTDOWN: nxt_state = HSBC_WAIT_BUS;
        HSBC_WAIT_BUS: begin
          if (stop_det || idle_det) begin
            nxt_state = HSBC_WAIT_CARD;
          end
        end
        HSBC_WAIT_CARD: begin
          if (card_high) begin
            nxt_state = HSBC_QUALIFY;
          end
        end
        HSBC_QUALIFY: begin
          if (!card_high) begin
            nxt_state = HSBC_WAIT_CARD;
          end else if (qual_cnt_ff == QW'(`HSBC_STOP_CYC - 1)) begin
            nxt_state = HSBC_CONNECTED;
          end
        end
        HSBC_CONNECTED: nxt_state = HSBC_CONNECTED;
        default: nxt_state = HSBC_LOCKOUT;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= HSBC_LOCKOUT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_ff != HSBC_QUALIFY) begin
      qual_cnt_ff <= '0;
    end else begin
      qual_cnt_ff <= qual_cnt_ff + 1'b1;
    end
  end

  // Status outputs, taken from the next state to save a cycle on enable loss
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
      precharge_o <= 1'b1;
      shutdown_o <= 1'b0;
    end else begin
      ready_o <= (nxt_state == HSBC_CONNECTED);
      precharge_o <= (nxt_state != HSBC_SHUTDOWN) && (nxt_state != HSBC_CONNECTED);
      shutdown_o <= (nxt_state == HSBC_SHUTDOWN);
    end
  end

  // Rise-time boost per line
  logic [3:0] boost_act;
  logic [3:0] rise_prev_ff;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_boost
      logic [BW-1:0] cnt_ff;
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          rise_prev_ff[gl] <= 1'b0;
          cnt_ff <= '0;
        end else begin
          rise_prev_ff[gl] <= filt_ff[gl];
          if (!connected) begin
            cnt_ff <= '0;
          end else if (filt_ff[gl] && !rise_prev_ff[gl]) begin
            cnt_ff <= BW'(BOOST_CYC);
          end else if (cnt_ff != '0) begin
            cnt_ff <= cnt_ff - 1'b1;
          end
        end
      end
      assign boost_act[gl] = (cnt_ff != '0);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      boost_o <= 4'h0;
    end else begin
      boost_o <= boost_act & {4{nxt_state == HSBC_CONNECTED}};
    end
  end

  // Wired-AND joining per bus: g 0 clock, g 1 data
  logic [3:0] drive;
  genvar gb;
  generate
    for (gb = 0; gb < 2; gb++) begin : g_join
      hsbc_own_t own_ff;
      hsbc_own_t nxt_own;
      logic [SW-1:0] settle_ff;
      logic bp;
      logic cd;
      assign bp = filt_ff[gb];
      assign cd = filt_ff[gb + 2];

      // A low seen while that side is boosting is ignored: the known missed-ack window
      always_comb begin
        nxt_own = own_ff;
        case (own_ff)
          HSBC_OWN_NONE: begin
            if (!bp && !boost_act[gb]) begin
              nxt_own = HSBC_OWN_BP;
            end else if (!cd && !boost_act[gb + 2]) begin
              nxt_own = HSBC_OWN_CARD;
            end
          end
          HSBC_OWN_BP: begin
            if (bp) begin
              nxt_own = HSBC_OWN_SETTLE;
            end
          end
          HSBC_OWN_CARD: begin
            if (cd) begin
              nxt_own = HSBC_OWN_SETTLE;
            end
          end
          HSBC_OWN_SETTLE: begin
            if (settle_ff == '0) begin
              nxt_own = HSBC_OWN_NONE;
            end
          end
          default: nxt_own = HSBC_OWN_NONE;
        endcase
        if (!connected) begin
          nxt_own = HSBC_OWN_NONE;
        end
      end

      // Settle lets our own released low clear the synchronisers before re-arming;
      // shorter than the pin latency and the released side is taken as a new low
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          own_ff <= HSBC_OWN_NONE;
          settle_ff <= '0;
        end else begin
          own_ff <= nxt_own;
          if (nxt_own == HSBC_OWN_SETTLE && own_ff != HSBC_OWN_SETTLE) begin
            settle_ff <= SW'(SETTLE_CYC + `HSBC_SYNC_LAT);
          end else if (settle_ff != '0) begin
            settle_ff <= settle_ff - 1'b1;
          end
        end
      end

      assign drive[gb] = (own_ff == HSBC_OWN_CARD);
      assign drive[gb + 2] = (own_ff == HSBC_OWN_BP);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_oe_n_o <= 4'hF;
      line_o <= 4'h0;
    end else begin
      line_oe_n_o <= ~(drive & {4{connected}});
      line_o <= 4'h0;
    end
  end

  // Wishbone classic slave, one wait state
  logic wb_req;
  logic [31:0] rd_data;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  always_comb begin
    rd_data = 32'h0000_0000;
    if (wb_adr_i == `HSBC_ADR_STATUS) begin
      rd_data[`HSBC_ST_STATE_LSB +: 3] = state_ff;
      rd_data[`HSBC_ST_READY] = ready_o;
      rd_data[`HSBC_ST_LOCKOUT] = (state_ff == HSBC_LOCKOUT);
      rd_data[`HSBC_ST_SHUTDOWN] = shutdown_o;
      rd_data[`HSBC_ST_PRECHARGE] = precharge_o;
      rd_data[`HSBC_ST_LINES_LSB +: 4] = filt_ff[3:0];
      rd_data[`HSBC_ST_BOOST_LSB +: 4] = boost_act;
    end else if (wb_adr_i == `HSBC_ADR_IDLE) begin
      rd_data[IDLE_W-1:0] = idle_cyc_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd_data : 32'h0000_0000;
    end
  end

  localparam logic [IDLE_W-1:0] IDLE_RST = IDLE_W'(`HSBC_IDLE_CYC);

  // Write lands at the edge where the master samples ack high
  genvar gs;
  generate
    for (gs = 0; gs < IDLE_W; gs++) begin : g_idle_reg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          idle_cyc_ff[gs] <= IDLE_RST[gs];
        end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
            && wb_adr_i == `HSBC_ADR_IDLE && wb_sel_i[gs / 8]) begin
          idle_cyc_ff[gs] <= wb_dat_i[gs];
        end
      end
    end
  endgenerate

endmodule : hsbc_top
`default_nettype wire

/* verification/hsbc_bus_model.sv */
// Pulled-up two-wire lines on backplane and card, wired with the block's pulls
`timescale 1ns/1ps
`default_nettype none
module hsbc_bus_model
  import hsbc_pkg::*;
(
  input wire logic [3:0] ext_low_i,
  input wire logic [3:0] oe_n_i,
  output hsbc_lines_t line_o
);
  // Pull-up wins unless any party pulls low
  assign line_o = ~ext_low_i & oe_n_i;
endmodule : hsbc_bus_model
`default_nettype wire

/* verification/hsbc_top_asserts.sv */
// Concurrent checks on the bus connect control ports
`timescale 1ns/1ps
`default_nettype none
module hsbc_top_asserts
  import hsbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic supply_ok_i,
  input wire hsbc_lines_t line_i,
  input wire logic [3:0] line_oe_n_o,
  input wire logic [3:0] boost_o,
  input wire logic ready_o,
  input wire logic precharge_o,
  input wire logic shutdown_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Outside low only: our own pull on the same line is excluded
  sequence s_bp_held;
    (ready_o && !line_i.backplane_data_line && line_oe_n_o[1]) [*8];
  endsequence
  sequence s_cclk_held;
    (ready_o && !line_i.card_clock_line && line_oe_n_o[2]) [*8];
  endsequence
  sequence s_bp_free;
    (ready_o && line_i.backplane_data_line && line_oe_n_o[1]) [*8];
  endsequence
  iso_idle_a: assert property (!ready_o [*3] |-> line_oe_n_o == 4'hF)
    else $error("lines joined while not ready");
  no_boost_a: assert property (!ready_o [*3] |-> boost_o == 4'h0)
    else $error("boost while not ready");
  sd_state_a: assert property (shutdown_o |-> !precharge_o && !ready_o)
    else $error("shutdown outputs wrong");
  pre_lock_a: assert property (!supply_ok_i [*6] |-> precharge_o && !ready_o && !shutdown_o)
    else $error("lockout outputs wrong");
  drop_ready_a: assert property (ready_o && !enable_i |-> ##[1:6] !ready_o)
    else $error("ready stays high after disable");
  bp_card_a: assert property (s_bp_held |-> !line_oe_n_o[3])
    else $error("backplane low not passed to card");
  card_bp_a: assert property (s_cclk_held |-> !line_oe_n_o[0])
    else $error("card low not passed to backplane");
  rel_join_a: assert property (s_bp_free |-> line_oe_n_o[3])
    else $error("card held low after release");
  boost_len_a: assert property (boost_o[1] |-> ##[1:4] !boost_o[1])
    else $error("boost too long");
  boost_conn_a: assert property (boost_o != 4'h0 |-> ready_o || $past(ready_o))
    else $error("boost while disconnected");
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer too long");
endmodule : hsbc_top_asserts
bind hsbc_top hsbc_top_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i),
  .supply_ok_i(supply_ok_i), .line_i(line_i), .line_oe_n_o(line_oe_n_o), .boost_o(boost_o),
  .ready_o(ready_o), .precharge_o(precharge_o), .shutdown_o(shutdown_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* verification/tb_hsbc_top.sv */
// Self-checking bench for the bus connect control
`timescale 1ns/1ps
`default_nettype none
module tb_hsbc_top;
  import hsbc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic enable_i = 1'b1;
  logic supply_ok_i = 1'b0;
  logic [3:0] ext_low = 4'h0;
  logic [2:0] wb_ctl = 3'h0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wd = 32'h0;
  logic [31:0] wb_rd, rd;
  logic [3:0] line_o, oe_n, boost, seen;
  logic wb_ack_o, ready, pre, sd;
  hsbc_lines_t line;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  hsbc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .enable_i(enable_i), .supply_ok_i(supply_ok_i),
    .line_i(line), .line_o(line_o), .line_oe_n_o(oe_n), .boost_o(boost), .ready_o(ready),
    .precharge_o(pre), .shutdown_o(sd), .wb_cyc_i(wb_ctl[2]), .wb_stb_i(wb_ctl[1]),
    .wb_we_i(wb_ctl[0]), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wd),
    .wb_dat_o(wb_rd), .wb_ack_o(wb_ack_o));
  hsbc_bus_model BUS (.ext_low_i(ext_low), .oe_n_i(oe_n), .line_o(line));
  task automatic summarize();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails = fails + 1;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen_v, input logic [31:0] exp);
    cmp_count++;
    if (seen_v !== exp) begin
      fails++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen_v);
    end
  endtask : chk
  // Request held until ack; the timeout ends a hang
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
    output logic [31:0] rdat);
    @(posedge clk_i);
    wb_ctl <= {2'b11, we};
    wb_adr <= adr;
    wb_wd <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_rd;
    wb_ctl <= 3'h0;
  endtask : wb
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask : tick
  task automatic wait_rdy(output int k);
    k = 0;
    while (ready !== 1'b1 && k < 300) begin
      @(posedge clk_i);
      k++;
    end
  endtask : wait_rdy
  initial begin
    tick(20);
    rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0, rd);
    chk("idle reset", rd, 32'h0000076C);
    wb(1'b1, 8'h04, 32'hFFFF0008, rd);
    wb(1'b0, 8'h04, 32'h0, rd);
    chk("idle rw", rd, 32'h00000008);
    wb(1'b1, 8'h00, 32'hFFFFFFFF, rd);
    wb(1'b0, 8'h0C, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    // Clock activity during lockout must be ignored
    ext_low <= 4'h5;
    tick(20);
    ext_low <= 4'h0;
    tick(20);
    wb(1'b0, 8'h00, 32'h0, rd);
    chk("lockout", {25'h0, rd[6:0]}, 32'h00000050);
    ext_low <= 4'h8;
    supply_ok_i <= 1'b1;
    tick(60);
    chk("card low", {ready, oe_n}, 5'h0F);
    ext_low <= 4'h0;
    wait_rdy(n);
    chk("ready", ready, 1'b1);
    chk("qual delay", n >= 24, 1'b1);
    chk("conn pins", {pre, sd, oe_n, boost}, 10'h0F0);
    ext_low <= 4'h2;
    tick(10);
    chk("bp to card", oe_n, 4'h7);
    chk("line out", line_o, 4'h0);
    ext_low <= 4'h0;
    seen = 4'h0;
    repeat (16) begin
      @(posedge clk_i);
      seen = seen | boost;
    end
    chk("release", oe_n, 4'hF);
    chk("boost", {seen[3], seen[1]}, 2'b11);
    ext_low <= 4'h4;
    tick(10);
    chk("card to bp", oe_n, 4'hE);
    ext_low <= 4'h0;
    tick(16);
    enable_i <= 1'b0;
    tick(8);
    chk("disable", {ready, pre, sd, oe_n, boost}, 11'h1F0);
    // Long idle so only a stop can qualify
    wb(1'b1, 8'h04, 32'h0000FFFF, rd);
    ext_low <= 4'h1;
    enable_i <= 1'b1;
    tick(100);
    chk("requalify", ready, 1'b0);
    ext_low <= 4'h0;
    tick(8);
    ext_low <= 4'h2;
    tick(8);
    ext_low <= 4'h0;
    wait_rdy(n);
    chk("stop", ready, 1'b1);
    summarize();
  end
endmodule : tb_hsbc_top
`default_nettype wire
